// ==== include/pmt_pkg.sv ====
// Constants shared by the period match timer and its scaler.
// Assumes a single 40 MHz pclk domain and a 32-bit APB register port.
`default_nettype none
package pmt_pkg;
	localparam int unsigned APB_AW       = 8;
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_COUNT   = 8'h04;
	localparam logic [7:0]  ADDR_PERIOD  = 8'h08;
	localparam logic [7:0]  ADDR_FLAGS   = 8'h0c;
	localparam logic [7:0]  ADDR_ENABLES = 8'h10;

	localparam int unsigned CTRL_PRE_LSB  = 0;
	localparam int unsigned CTRL_RUN_BIT  = 2;
	localparam int unsigned CTRL_POST_LSB = 3;
	localparam logic [7:0]  CTRL_MASK     = 8'h7f;
	localparam int unsigned FLAG_BIT      = 1;

	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [7:0]  COUNT_RST  = 8'h00;
	localparam logic [7:0]  PERIOD_RST = 8'hff;

	localparam logic [1:0]  INSTR_LAST = 2'h3;
	localparam logic [3:0]  PRE_LIM_1  = 4'h0;
	localparam logic [3:0]  PRE_LIM_4  = 4'h3;
	localparam logic [3:0]  PRE_LIM_16 = 4'hf;

	typedef enum logic [1:0] {
		PRE_DIV1   = 2'b00,
		PRE_DIV4   = 2'b01,
		PRE_DIV16A = 2'b10,
		PRE_DIV16B = 2'b11
	} pmt_pre_t;
endpackage
`default_nettype wire

// ==== include/pmt_scl_if.sv ====
// Link between the timer core and its prescaler/postscaler.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface pmt_scl_if;
	logic           itick;
	logic           run;
	logic           clear;
	logic           match;
	pmt_pkg::pmt_pre_t pre_sel;
	logic [3:0]     post_sel;
	logic           inc_tick;
	logic           post_done;
	modport timer  (output itick, run, clear, match, pre_sel, post_sel, input inc_tick, post_done);
	modport scaler (input itick, run, clear, match, pre_sel, post_sel, output inc_tick, post_done);
endinterface
`default_nettype wire

// ==== rtl/pmt_scaler.sv ====
// Prescaler in front of the counter and postscaler behind the match.
// Assumes itick and match already include the clock enable.
`timescale 1ns/1ps
`default_nettype none
module pmt_scaler (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	pmt_scl_if.scaler s
);
	logic [3:0] pre_r;
	logic [3:0] post_r;
	logic [3:0] pre_lim;
	logic       pre_wrap;

	assign pre_lim   = (s.pre_sel == pmt_pkg::PRE_DIV1) ? pmt_pkg::PRE_LIM_1 :
	                   (s.pre_sel == pmt_pkg::PRE_DIV4) ? pmt_pkg::PRE_LIM_4 : pmt_pkg::PRE_LIM_16; // RQ2
	assign pre_wrap  = pre_r == pre_lim;
	// A stopped timer and a pending clear both block the tick.
	assign s.inc_tick  = s.run & s.itick & pre_wrap & ~s.clear; // RQ15
	assign s.post_done = s.match & (post_r == s.post_sel); // RQ4

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r  <= 4'h0;
			post_r <= 4'h0;
		end else if (ce) begin
			if (s.clear) begin
				pre_r  <= 4'h0; // RQ7
				post_r <= 4'h0; // RQ7
			end else begin
				if (s.run & s.itick)
					pre_r <= pre_wrap ? 4'h0 : pre_r + 4'h1;
				if (s.match)
					post_r <= s.post_done ? 4'h0 : post_r + 4'h1;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_SCL_CLEAR: assert property (ce && s.clear |=> pre_r == 4'h0 && post_r == 4'h0) // RQ7
		else $error("scaler not cleared");
	AST_SCL_RATIO: assert property (s.post_done |-> post_r == s.post_sel && s.match) // RQ4
		else $error("postscale ratio wrong");
	AST_SCL_DIV4: assert property (s.inc_tick && s.pre_sel == pmt_pkg::PRE_DIV4 |-> pre_r == 4'h3) // RQ2
		else $error("divide by four wrong");
endmodule
`default_nettype wire

// ==== rtl/pmt_top.sv ====
// Eight-bit period match timer with APB register access.
// Assumes pclk is the oscillator clock; the instruction clock is pclk divided by four.
//
// How it works
// [RQ1] An 8-bit counter and an 8-bit period register are both readable and writable.
// [RQ2] The counter advances on instruction ticks divided by 1, 4 or 16 as the prescale field selects.
// [RQ3] The counter counts up from zero to the period value and then returns to zero on the next tick.
// [RQ4] Each match advances a postscaler whose ratio is its four-bit field plus one.
// [RQ5] A completed postscale count sets the match interrupt flag at bit 1 of the flag register.
// [RQ6] Control bit 2 runs the timer when set and stops it when clear.
// [RQ7] Writes to the counter or control register and any reset clear both scalers.
// [RQ8] A control write leaves the counter value as it was.
// [RQ9] Reset clears the counter.
// [RQ10] Reset sets the period register to all ones.
// [RQ11] The unscaled match pulse is offered as a shift clock source for the serial port.
// [RQ12] The match pulse and the live count serve as the PWM time base.
// [RQ13] Control bit 7 reads as zero and ignores writes.
// [RQ14] The flag holds until software clears it, and the request needs flag and enable together.
// [RQ15] A stopped timer holds counter and scalers and raises no match or flag.
`timescale 1ns/1ps
`default_nettype none
module pmt_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             match_pulse,
	output logic      [7:0]  timebase_count,
	output logic             irq_req
);
	pmt_scl_if scl ();

	logic [7:0]  ctrl_r;
	logic [7:0]  count_r;
	logic [7:0]  period_r;
	logic        flag_r;
	logic        en_r;
	logic [1:0]  idiv_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;
	logic        match_r;
	logic        irq_r;

	logic [7:0]  ctrl_nxt;
	logic [7:0]  count_nxt;
	logic [7:0]  period_nxt;
	logic        flag_nxt;
	logic        en_nxt;

	// Bus decode.
	logic        access;
	logic        fire;
	logic        wr_fire;
	logic        sel_ctrl;
	logic        sel_count;
	logic        sel_period;
	logic        sel_flags;
	logic        sel_enables;
	logic        addr_hit;
	logic        wr_ctrl;
	logic        wr_count;
	logic        wr_period;
	logic        wr_flags;
	logic        wr_enables;
	logic [7:0]  rd_byte;
	logic [7:0]  wr_byte;

	// Timer datapath.
	logic        run;
	logic        at_period;
	logic        match_evt;

	// The access phase always takes one wait state so that read data comes from a flip-flop.
	assign access   = ce & psel & penable & ~pready_r;
	assign fire     = ce & psel & penable & pready_r;
	assign wr_fire  = fire & pwrite;
	assign wr_byte  = pwdata[7:0];

	assign sel_ctrl    = paddr == pmt_pkg::ADDR_CTRL;
	assign sel_count   = paddr == pmt_pkg::ADDR_COUNT;
	assign sel_period  = paddr == pmt_pkg::ADDR_PERIOD;
	assign sel_flags   = paddr == pmt_pkg::ADDR_FLAGS;
	assign sel_enables = paddr == pmt_pkg::ADDR_ENABLES;
	assign addr_hit    = sel_ctrl | sel_count | sel_period | sel_flags | sel_enables;

	assign wr_ctrl    = wr_fire & sel_ctrl;
	assign wr_count   = wr_fire & sel_count;
	assign wr_period  = wr_fire & sel_period;
	assign wr_flags   = wr_fire & sel_flags;
	assign wr_enables = wr_fire & sel_enables;

	assign rd_byte = sel_ctrl    ? ctrl_r :
	                 sel_count   ? count_r :
	                 sel_period  ? period_r :
	                 sel_flags   ? {6'h00, flag_r, 1'b0} :
	                 sel_enables ? {6'h00, en_r, 1'b0} : 8'h00; // RQ1

	// Scaler hookup.
	assign run          = ctrl_r[pmt_pkg::CTRL_RUN_BIT]; // RQ6
	assign scl.itick    = ce & (idiv_r == pmt_pkg::INSTR_LAST);
	assign scl.run      = run;
	assign scl.clear    = wr_count | wr_ctrl; // RQ7
	assign scl.pre_sel  = pmt_pkg::pmt_pre_t'(ctrl_r[pmt_pkg::CTRL_PRE_LSB +: 2]);
	assign scl.post_sel = ctrl_r[pmt_pkg::CTRL_POST_LSB +: 4];
	assign scl.match    = match_evt;

	pmt_scaler u_scaler (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.s       (scl)
	);

	// A counter write in the same cycle as a tick wins and produces no match.
	assign at_period = count_r == period_r;
	assign match_evt = scl.inc_tick & at_period; // RQ3

	assign ctrl_nxt   = wr_ctrl ? (wr_byte & pmt_pkg::CTRL_MASK) : ctrl_r; // RQ13
	assign count_nxt  = wr_count      ? wr_byte : // RQ1
	                    match_evt     ? 8'h00 : // RQ3
	                    scl.inc_tick  ? count_r + 8'h01 : count_r; // RQ8
	assign period_nxt = wr_period ? wr_byte : period_r; // RQ1
	// Hardware set wins over a software clear in the same cycle.
	assign flag_nxt   = scl.post_done | (wr_flags ? wr_byte[pmt_pkg::FLAG_BIT] : flag_r); // RQ5
	assign en_nxt     = wr_enables ? wr_byte[pmt_pkg::FLAG_BIT] : en_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= pmt_pkg::CTRL_RST;
			count_r  <= pmt_pkg::COUNT_RST; // RQ9
			period_r <= pmt_pkg::PERIOD_RST; // RQ10
		end else if (ce) begin
			ctrl_r   <= ctrl_nxt;
			count_r  <= count_nxt;
			period_r <= period_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= 1'b0;
			en_r   <= 1'b0;
			irq_r  <= 1'b0;
		end else if (ce) begin
			flag_r <= flag_nxt; // RQ14
			en_r   <= en_nxt;
			irq_r  <= flag_r & en_r; // RQ14
		end
	end

	// Instruction clock divider runs free so that run only gates the prescaler.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idiv_r <= 2'h0;
		else if (ce)
			idiv_r <= idiv_r + 2'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			match_r <= 1'b0;
		else if (ce)
			match_r <= match_evt; // RQ11
	end

	// Unmapped addresses answer with pslverr and read zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else if (ce) begin
			pready_r  <= access;
			pslverr_r <= access & ~addr_hit;
			if (access)
				prdata_r <= {24'h00_0000, rd_byte};
		end
	end

	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign match_pulse    = match_r; // RQ11
	assign timebase_count = count_r; // RQ12
	assign irq_req        = irq_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_CTRL_TOP_BIT: assert property (ctrl_r[7] == 1'b0) // RQ13
		else $error("control bit 7 set");

	AST_WRAP_ZERO: assert property (match_evt |=> count_r == 8'h00 && match_r) // RQ3
		else $error("counter did not wrap on match");

	AST_COUNT_UP: assert property (scl.inc_tick && !at_period && !wr_count |=> count_r == $past(count_r) + 8'h01) // RQ3
		else $error("counter did not advance");

	AST_STOP_HOLDS: assert property (!run && !wr_count && !wr_ctrl |=> $stable(count_r) && !match_r) // RQ15
		else $error("stopped timer moved");

	AST_CTRL_KEEPS: assert property (wr_ctrl |=> count_r == $past(count_r)) // RQ8
		else $error("control write changed count");

	AST_COUNT_WRITE: assert property (wr_count |=> count_r == $past(wr_byte)) // RQ1
		else $error("count write lost");

	AST_FLAG_SET: assert property (scl.post_done |=> flag_r ##1 (flag_r || $past(wr_flags))) // RQ5
		else $error("flag not set on postscale");

	AST_FLAG_STICKY: assert property (flag_r && !wr_flags |=> flag_r) // RQ14
		else $error("flag dropped by itself");

	AST_IRQ_GATE: assert property (irq_r |-> $past(flag_r) && $past(en_r)) // RQ14
		else $error("request without flag and enable");

	AST_RUN_GATE: assert property (!run |-> !scl.inc_tick) // RQ6
		else $error("tick while stopped");

	AST_PERIOD_WRITE: assert property (wr_period |=> period_r == $past(wr_byte)) // RQ1
		else $error("period write lost");

	AST_PREADY_PULSE: assert property (pready_r |=> !pready_r || !ce)
		else $error("pready held too long");

	COV_MATCH: cover property (match_evt);
	COV_POST16: cover property (scl.post_done && scl.post_sel == 4'hf);
	COV_SET_CLEAR: cover property (scl.post_done && wr_flags);
	COV_UNMAPPED: cover property (pslverr_r);
endmodule
`default_nettype wire

// ==== dv/tb_pmt_top.sv ====
// Self-checking testbench for the period match timer, driven over APB.
// Assumes pmt_pkg, pmt_scl_if and the rtl modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_pmt_top;
	logic        pclk;
	logic        presetn;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        match_pulse;
	logic [7:0]  timebase_count;
	logic        irq_req;
	logic [31:0] rd;
	logic        er;
	int          miscompares;
	int          n_compared;
	int          nm;
	int          c;
	int          nm0;
	logic [3:0]  ps [4] = '{4'h0, 4'h1, 4'h7, 4'hf};

	pmt_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .match_pulse(match_pulse), .timebase_count(timebase_count), .irq_req(irq_req));

	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;

	// Match pulses are counted here so postscale ratios can be judged against the flag.
	always @(posedge pclk) begin
		if (match_pulse === 1'b1)
			nm <= nm + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// The request is held until pready is seen high; data is taken in that same cycle.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		rd      = prdata;
		er      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(er, 32'h0);
	endtask

	// Cycles from one match pulse to the next, bounded so a dead timer cannot hang the run.
	task automatic gap(output int g);
		int n;
		n = 0;
		while (match_pulse !== 1'b1 && n < 2000) begin
			@(negedge pclk);
			n++;
		end
		g = 0;
		do begin
			@(negedge pclk);
			g++;
		end while (match_pulse !== 1'b1 && g < 2000);
	endtask

	task automatic waitirq;
		int n;
		n = 0;
		while (irq_req !== 1'b1 && n < 2000) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 2000)
			miscompares++;
	endtask

	task automatic results;
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#500000;
		miscompares++;
		results();
	end

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		miscompares = 0;
		n_compared = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rc(pmt_pkg::ADDR_CTRL, 32'h0);
		rc(pmt_pkg::ADDR_COUNT, 32'h0);
		rc(pmt_pkg::ADDR_PERIOD, 32'hff);
		rc(pmt_pkg::ADDR_FLAGS, 32'h0);
		wr(pmt_pkg::ADDR_CTRL, 32'hff);
		rc(pmt_pkg::ADDR_CTRL, 32'h7f);
		wr(pmt_pkg::ADDR_CTRL, 32'h78);
		wr(pmt_pkg::ADDR_PERIOD, 32'h5a);
		rc(pmt_pkg::ADDR_PERIOD, 32'h5a);
		wr(pmt_pkg::ADDR_COUNT, 32'h42);
		wr(pmt_pkg::ADDR_CTRL, 32'h01);
		repeat (100) @(posedge pclk);
		rc(pmt_pkg::ADDR_COUNT, 32'h42);
		chk(timebase_count, 32'h42);
		apb(1'b0, 8'h14, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		// Period 3 keeps each measured interval short: (3 + 1) counts of the prescaled tick.
		wr(pmt_pkg::ADDR_PERIOD, 32'h3);
		for (int k = 0; k < 4; k++) begin
			wr(pmt_pkg::ADDR_COUNT, 32'h0);
			wr(pmt_pkg::ADDR_CTRL, 32'h4 | k);
			gap(c);
			chk(c, 16 * ((k == 0) ? 1 : (k == 1) ? 4 : 16));
		end
		wr(pmt_pkg::ADDR_ENABLES, 32'h2);
		for (int i = 0; i < 4; i++) begin
			wr(pmt_pkg::ADDR_CTRL, 32'h0);
			wr(pmt_pkg::ADDR_FLAGS, 32'h0);
			nm0 = nm;
			wr(pmt_pkg::ADDR_CTRL, {ps[i], 3'b100});
			waitirq();
			chk(nm - nm0, ps[i] + 1);
		end
		wr(pmt_pkg::ADDR_CTRL, 32'h0);
		rc(pmt_pkg::ADDR_FLAGS, 32'h2);
		wr(pmt_pkg::ADDR_ENABLES, 32'h0);
		repeat (3) @(posedge pclk);
		chk(irq_req, 32'h0);
		rc(pmt_pkg::ADDR_FLAGS, 32'h2);
		wr(pmt_pkg::ADDR_FLAGS, 32'h0);
		rc(pmt_pkg::ADDR_FLAGS, 32'h0);
		wr(pmt_pkg::ADDR_CTRL, 32'h04);
		repeat (20) @(posedge pclk);
		// A freeze of 22 cycles spans 5 or 6 counts, never a whole number of laps of period 3.
		ce <= 1'b0;
		repeat (2) @(posedge pclk);
		c = timebase_count;
		repeat (22) @(posedge pclk);
		chk(timebase_count, c);
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rc(pmt_pkg::ADDR_COUNT, 32'h0);
		rc(pmt_pkg::ADDR_PERIOD, 32'hff);
		rc(pmt_pkg::ADDR_CTRL, 32'h0);
		results();
	end
endmodule
`default_nettype wire
